// [src/pic_capture_channel.sv]
`timescale 1ns/10ps
`default_nettype none
module pic_capture_channel #(
  parameter int CNT_W = pic_pkg::CNT_W
) (
  input  wire logic             core_clk,          // Main operation clock, 100 MHz
  input  wire logic             srst,              // Synchronous reset, active high
  input  wire logic             capture_input_pin, // Pulse input from outside
  input  wire logic             channel_start_bit, // One-cycle write of 1 starts channel
  input  wire logic             channel_stop_bit,  // One-cycle write of 1 stops channel
  input  wire logic             capture_mode,      // 1 capture, 0 compare
  input  wire logic [1:0]       edge_sel,          // Valid edge selection
  input  wire logic             trig_sel,          // Capture trigger source
  input  wire logic             soft_trigger,      // Software capture pulse
  output logic                  channel_enabled,   // Counting enabled
  output logic [CNT_W-1:0]      channel_count_register,   // Live count
  output logic [CNT_W-1:0]      channel_capture_register, // Last captured count
  output logic                  capture_complete_interrupt // One-cycle pulse
);
  logic             edge_pulse;
  logic             trigger;
  logic             run_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] cap_reg;
  logic             irq_reg;

  pic_edge_detect u_edge (
    .core_clk  (core_clk),
    .srst      (srst),
    .pin_async (capture_input_pin), // R1
    .edge_sel  (edge_sel),
    .edge_pulse(edge_pulse)
  );

  // Only the pin edge triggers in pin mode; soft trigger kept for other setups
  assign trigger = run_reg & capture_mode &                                  // R2
                   ((trig_sel == pic_pkg::TRIG_PIN) ? edge_pulse : soft_trigger); // R5

  always_ff @(posedge core_clk) begin
    if (srst) begin
      run_reg <= 1'b0;
    end else if (channel_start_bit) begin
      run_reg <= 1'b1; // R6
    end else if (channel_stop_bit) begin
      run_reg <= 1'b0;
    end
  end

  // Counter ticks every clock: no prescaler in this configuration
  always_comb begin
    if (channel_start_bit) begin
      cnt_next = CNT_W'(pic_pkg::CNT_CLEAR); // R7
    end else if (!run_reg) begin
      cnt_next = cnt_reg;
    end else if (trigger) begin
      cnt_next = CNT_W'(pic_pkg::CNT_CLEAR); // R10
    end else begin
      cnt_next = cnt_reg + CNT_W'(pic_pkg::CNT_STEP); // R3 R12
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_reg <= CNT_W'(pic_pkg::CNT_CLEAR);
    end else begin
      cnt_reg <= cnt_next; // R1
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cap_reg <= CNT_W'(pic_pkg::CAP_RESET);
    end else if (trigger && !channel_start_bit) begin
      cap_reg <= cnt_reg; // R8
    end
  end

  // Interrupt fires with the capture register already updated
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= trigger && !channel_start_bit; // R9
    end
  end

  assign channel_enabled            = run_reg;
  assign channel_count_register     = cnt_reg;
  assign channel_capture_register   = cap_reg;
  assign capture_complete_interrupt = irq_reg;
endmodule : pic_capture_channel
`default_nettype wire

// [shared/pic_pkg.sv]
// Overview of operation
// [R1] Counter is 16 bits wide and is fed by the main operation clock; the capture input pin triggers captures.
// [R2] Capture mode samples the counter on input edges instead of comparing.
// [R3] Counter advances at the undivided main operation clock rate.
// [R4] Edge detector can select rising edges; here only rising edges count (edge_sel in the code also selects falling or both).
// [R5] Trigger source selectable so a valid pin edge causes the capture.
// [R6] Software writes 1 to the channel start bit to enable counting.
// [R7] Writing start clears the counter to 0000H, then counting begins.
// [R8] Every valid edge copies the counter into the capture register; the code skips an edge that falls in the cycle the start bit is written.
// [R9] Capture-complete interrupt is raised once the capture has finished.
// [R10] After each capture the counter clears to 0000H and keeps counting.
// [R11] Software discards the first capture after start; later ones are kept.
// [R12] Counter increments each clock and wraps from maximum to zero.
package pic_pkg;
  localparam int          CNT_W      = 16;
  localparam logic [15:0] CNT_CLEAR  = 16'h0000;
  localparam logic [15:0] CNT_STEP   = 16'h0001;
  localparam logic [15:0] CAP_RESET  = 16'h0000;

  // Edge selection codes
  localparam logic [1:0]  EDGE_FALL  = 2'h0;
  localparam logic [1:0]  EDGE_RISE  = 2'h1;
  localparam logic [1:0]  EDGE_BOTH  = 2'h2;

  // Capture trigger source codes
  localparam logic        TRIG_SOFT  = 1'h0;
  localparam logic        TRIG_PIN   = 1'h1;
endpackage : pic_pkg

// [src/pic_edge_detect.sv]
`timescale 1ns/10ps
`default_nettype none
module pic_edge_detect (
  input  wire logic       core_clk,   // Main operation clock
  input  wire logic       srst,       // Synchronous reset
  input  wire logic       pin_async,  // Raw pin level
  input  wire logic [1:0] edge_sel,   // Valid edge selection
  output logic            edge_pulse  // One-cycle valid edge
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic rise;
  logic fall;

  // Two-stage synchroniser; only sync2 reads sync1
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= pin_async;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  always_comb begin
    unique case (edge_sel)
      pic_pkg::EDGE_FALL: edge_pulse = fall;
      pic_pkg::EDGE_RISE: edge_pulse = rise; // R4
      pic_pkg::EDGE_BOTH: edge_pulse = rise | fall;
      default:            edge_pulse = 1'b0;
    endcase
  end
endmodule : pic_edge_detect
`default_nettype wire

// [bench/pic_capture_channel_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module pic_capture_channel_asserts #(parameter int CNT_W = 16) (
  input wire logic core_clk,
  srst,
  capture_input_pin,
  channel_start_bit,
  channel_enabled,
  capture_complete_interrupt,
  input wire logic [CNT_W-1:0] channel_count_register,
  channel_capture_register
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  wire irq = capture_complete_interrupt;
  wire [CNT_W-1:0] cnt = channel_count_register;
  wire go = channel_enabled && !channel_start_bit;
  a_count_up: assert property (go ##1 !irq |-> cnt == $past(cnt)+1'b1) else $error("up");
  a_start_clear: assert property (channel_start_bit |=> channel_enabled && cnt == '0)
    else $error("start");
  a_rise_capture: assert property ($rose(capture_input_pin) ##0 go[*3] |=> irq)
    else $error("miss");
  a_idle_quiet: assert property (!channel_enabled |=> !irq) else $error("idle");
  a_irq_clear: assert property (irq |-> cnt == '0) else $error("clear");
  a_cap_value: assert property (irq |-> channel_capture_register == $past(cnt))
    else $error("value");
  a_cap_hold: assert property (!irq |-> $stable(channel_capture_register))
    else $error("hold");
  a_irq_pulse: assert property (irq |=> !irq) else $error("pulse");
endmodule : pic_capture_channel_asserts
bind pic_capture_channel pic_capture_channel_asserts #(.CNT_W(CNT_W)) i_chk (.*);
`default_nettype wire

// [bench/pic_pulse_src.sv]
`timescale 1ns/10ps
`default_nettype none
module pic_pulse_src (
  input  wire logic       core_clk, // Clock
  input  wire logic [2:0] gap,      // Level length less three
  output logic            pin = 1'b0 // Pulse line
);
  logic [3:0] n = 4'h0;
  // Each level lasts at least three cycles so the synchroniser never misses it
  always @(negedge core_clk) {n, pin} <= (n > gap + 4'h1) ? {4'h0, ~pin} : {n + 4'h1, pin};
endmodule : pic_pulse_src
`default_nettype wire

// [bench/pulse_interval_capture_channel_test.sv]
`timescale 1ns/10ps
`default_nettype none
module pulse_interval_capture_channel_test;
  logic        core_clk = 1'b0, srst = 1'b1, start = 1'b0, pin, irq;
  logic [2:0]  gap = 3'h0;
  logic [15:0] cap, seed = 16'hE3FB;
  logic        en;
  logic [15:0] cnt;
  int          fails = 0, tests_run = 0;
  initial forever #5 core_clk = ~core_clk;
  pic_pulse_src i_src (.core_clk(core_clk), .gap(gap), .pin(pin));
  pic_capture_channel i_dut (.core_clk(core_clk), .srst(srst), .capture_input_pin(pin),
    .channel_start_bit(start), .channel_stop_bit(1'b0), .capture_mode(1'b1), .edge_sel(2'h1),
    .trig_sel(1'b1), .soft_trigger(1'b0), .channel_enabled(en), .channel_count_register(cnt),
    .channel_capture_register(cap), .capture_complete_interrupt(irq));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [15:0] want(input logic [2:0] g);
    return 16'(2 * g + 5);
  endfunction : want
  task automatic check(input logic [15:0] seen, exp_v);
    tests_run++;
    if (seen !== exp_v) fails++;
    if (seen !== exp_v) $display("wrong value capture expected %h seen %h", exp_v, seen);
  endtask : check
  task automatic wrap_up;
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial begin
    #20000 fails++;
    wrap_up();
  end
  initial begin
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    check({15'h0000, en}, 16'h0000);
    check(cnt, 16'h0000);
    @(negedge core_clk) start = 1'b1;
    @(negedge core_clk) start = 1'b0;
    check({15'h0000, en}, 16'h0001);
    check(cnt, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      gap <= (i < 2) ? {3{i[0]}} : seed[2:0];
      // Settle on the new period first; the start-to-edge capture is never checked
      repeat (50) @(negedge core_clk);
      for (int k = 0; k < 25 && irq !== 1'b1; k++) @(negedge core_clk);
      check(cap, want(gap));
    end
    // Mid-run reset must return every output to its idle value
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    check({15'h0000, en}, 16'h0000);
    check(cnt, 16'h0000);
    check(cap, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    wrap_up();
  end
endmodule : pulse_interval_capture_channel_test
`default_nettype wire
